// *** lhpdm_pkg.sv ***
package lhpdm_pkg;
  localparam int ADDR_W = 11;
  localparam int MEM_DEPTH = 1280;
  localparam int COL_NUM = 105;
  localparam int ROW_NUM = 68;
  localparam logic [6:0] COL_LAST_OFF = 7'h68;
  localparam logic [6:0] COL_MAX_IDX = 7'h68;
  localparam logic [6:0] ROW_MAX_IDX = 7'h43;
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 8;
  localparam logic [1:0] KIND_INSTR = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_READ = 2'h2;
  // interface select: upper two pins
  localparam logic [1:0] IM_SERIAL = 2'h0;
  localparam logic [1:0] IM_BUS68 = 2'h1;
  localparam logic [1:0] IM_BUS80 = 2'h3;
  // serial frame: rw bit, select bit, eight data bits msb first
  localparam logic [3:0] SER_LAST_BIT = 4'h9;
  localparam logic [3:0] SER_FIRST_DATA = 4'h2;
  // instruction codes
  localparam logic [7:0] OP_ADDR_LO_MASK = 8'h80;
  localparam logic [7:0] OP_MASK4 = 8'hf0;
  localparam logic [7:0] OP_ADDR_HI = 8'h10;
  localparam logic [7:0] OP_ENTRY = 8'h20;
  localparam logic [7:0] OP_DRIVER = 8'h30;
  localparam logic [7:0] OP_POWER = 8'h40;
  localparam logic [7:0] OP_OSC_START = 8'h50;
  localparam logic [7:0] OP_LINES = 8'h60;
  localparam int ENTRY_DIR_BIT = 1;
  localparam int ENTRY_HOLD_BIT = 0;
  localparam int DRV_ROWDIR_BIT = 1;
  localparam int DRV_COLDIR_BIT = 0;
  localparam int PWR_DISP_BIT = 3;
  localparam int PWR_SLEEP_BIT = 2;
  localparam int PWR_STBY_BIT = 1;
  // reset values
  localparam logic RST_DIR = 1'b1;
  localparam logic [3:0] RST_LINE_GROUPS = 4'h8;
  // internal oscillator: display tick every this many plus one clk_sys cycles
  localparam logic [7:0] OSC_DIV_LAST = 8'h07;
  typedef enum logic [0:0] {LHPDM_SLOT_DISP, LHPDM_SLOT_HOST} lhpdm_slot_type;
endpackage : lhpdm_pkg

// *** lhpdm_top.sv ***
// How it works
// - serial, 68-style and 80-style buses, 4 or 8 bit, chosen by select pins
// - two 8-bit host registers: instruction register and data holding register
// - select low write loads instruction; select high write/read accesses memory
// - every data byte written outside sleep or standby goes to memory at the counter, automatically
// - an address set fetches the addressed byte into the data register
// - first read after address set is stale; later reads valid
// - after each read the next address is fetched for the next read
// - instructions take effect at once, back to back allowed
// - address set copies its value into the address counter
// - counter steps by one up or down after every memory write
// - after a read the counter steps or holds per the read-hold bit
// - memory holds the 128 by 80 dot pattern, one means lit
// - display reads and host operations use separate time slots
// - 68 row and 105 column drivers; only programmed rows are scanned, zero groups runs the row count to 127
// - line data shifts into 105-bit register, latched when complete
// - column and row direction bits steer shift and scan order
// - display off, sleep or standby drive all driver outputs low
// - oscillator stops in standby; an external clock may be used instead
// - normal column direction maps columns to offsets 0x00 to 0x68
// - reversed column direction maps column 1 to offset 0x68
// - each eight-row group is a page stepping by 0x80, bit 0 first row
// - offsets 0x69 to 0x7f are stored but never displayed
// - direction bit one increments, zero decrements the counter
// - read-hold clear steps after reads, set keeps the counter
`timescale 1ns/100ps
`default_nettype none

module lhpdm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic doPush;
  logic doPop;

  assign inReady = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = store[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      store[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end
endmodule : lhpdm_fifo

module lhpdm_top
  import lhpdm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [2:0] interfaceSelectPins,
  input wire logic chipSelectN,
  input wire logic registerSelect,
  input wire logic strobeClkIn,
  input wire logic rwSdaIn,
  output logic rwSdaOut,
  output logic rwSdaOe,
  input wire logic [7:0] hostDataBusIn,
  output logic [7:0] hostDataBusOut,
  output logic hostDataBusOe,
  input wire logic oscillatorInputPin,
  input wire logic extClockSel,
  output logic oscRun,
  output logic hostBusy,
  output logic [COL_NUM-1:0] columnDriverOutput,
  output logic [ROW_NUM-1:0] rowDriverOutput
);
  // all pin inputs pass two flops before use
  logic [16:0] syncA;
  logic [16:0] syncB;
  logic strobeD;
  logic rwD;
  logic oscD;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // select rests high, so no pin edge counts before the first select
      syncA <= 17'h01000;
      syncB <= 17'h01000;
      strobeD <= 1'b0;
      rwD <= 1'b0;
      oscD <= 1'b0;
    end else begin
      syncA <= {extClockSel, interfaceSelectPins, chipSelectN, registerSelect, strobeClkIn,
                rwSdaIn, hostDataBusIn, oscillatorInputPin};
      syncB <= syncA;
      strobeD <= syncB[10];
      rwD <= syncB[9];
      oscD <= syncB[0];
    end
  end
  logic extSel;
  assign extSel = syncB[16];
  logic [1:0] imMode;
  logic narrowBus;
  logic csN;
  logic rs;
  logic strobe;
  logic rwPin;
  logic [7:0] dbIn;
  assign imMode = syncB[15:14];
  assign narrowBus = syncB[13];
  assign csN = syncB[12];
  assign rs = syncB[11];
  assign strobe = syncB[10];
  assign rwPin = syncB[9];
  assign dbIn = syncB[8:1];
  logic stRise;
  logic stFall;
  assign stRise = strobe && !strobeD;
  assign stFall = !strobe && strobeD;

  // ---------------- host pin front end ----------------
  logic [7:0] rdOut;
  logic evValid;
  logic [FIFO_W-1:0] evData;
  logic fifoInReady;
  logic [3:0] bitCnt;
  logic serRw;
  logic serRs;
  logic [7:0] serShift;
  logic nibbleHi;
  logic [3:0] nibbleHold;
  logic busWrEdge;
  logic busRdEnd;
  logic busRdActive;
  // 68 style: E falls ends an access; 80 style: WR*/RD* rising ends it
  assign busWrEdge = (imMode == IM_BUS68) ? (stFall && !rwPin) : stRise;
  assign busRdEnd = (imMode == IM_BUS68) ? (stFall && rwPin) : (rwPin && !rwD);
  assign busRdActive = (imMode == IM_BUS68) ? (strobe && rwPin) : !rwPin;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bitCnt <= '0;
      serRw <= 1'b0;
      serRs <= 1'b0;
      serShift <= '0;
      nibbleHi <= 1'b1;
      nibbleHold <= '0;
      evValid <= 1'b0;
      evData <= '0;
    end else begin
      evValid <= 1'b0;
      if (csN) begin
        bitCnt <= '0;
        nibbleHi <= 1'b1;
      end else if (imMode == IM_SERIAL) begin
        if (stRise) begin
          bitCnt <= (bitCnt == SER_LAST_BIT) ? '0 : bitCnt + 4'h1;
          if (bitCnt == 4'h0) begin
            serRw <= rwPin;
          end else if (bitCnt == 4'h1) begin
            serRs <= rwPin;
          end else begin
            serShift <= {serShift[6:0], rwPin};
          end
          if (bitCnt == SER_LAST_BIT) begin
            evValid <= serRw ? serRs : 1'b1;
            evData <= serRw ? {KIND_READ, 8'h00}
                            : {serRs ? KIND_WRITE : KIND_INSTR, serShift[6:0], rwPin};
          end
        end
      end else if (rs || !(busRdEnd || busRdActive)) begin
        if (busWrEdge && (!busRdActive || imMode == IM_BUS68)) begin
          nibbleHi <= narrowBus ? !nibbleHi : 1'b1;
          nibbleHold <= dbIn[7:4];
          // 4-bit bus: high nibble first on the upper four lines
          if (!narrowBus || !nibbleHi) begin
            evValid <= 1'b1;
            evData <= {rs ? KIND_WRITE : KIND_INSTR,
                       narrowBus ? {nibbleHold, dbIn[7:4]} : dbIn};
          end
        end else if (busRdEnd && rs) begin
          nibbleHi <= narrowBus ? !nibbleHi : 1'b1;
          if (!narrowBus || !nibbleHi) begin
            evValid <= 1'b1;
            evData <= {KIND_READ, 8'h00};
          end
        end
      end
    end
  end

  // read data onto the pins; enables come from flops so the bus turns one cycle late
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hostDataBusOut <= '0;
      hostDataBusOe <= 1'b0;
      rwSdaOut <= 1'b0;
      rwSdaOe <= 1'b0;
      hostBusy <= 1'b0;
    end else begin
      hostBusy <= !fifoInReady;
      hostDataBusOe <= !csN && rs && (imMode != IM_SERIAL) && busRdActive;
      hostDataBusOut <= (narrowBus && !nibbleHi) ? {rdOut[3:0], 4'h0} : rdOut;
      if (csN || imMode != IM_SERIAL) begin
        rwSdaOe <= 1'b0;
      end else if (stFall && serRw && bitCnt >= SER_FIRST_DATA) begin
        rwSdaOe <= 1'b1;
        rwSdaOut <= rdOut[3'(4'h9 - bitCnt)];
      end else if (stFall && bitCnt == 4'h0) begin
        rwSdaOe <= 1'b0;
      end
    end
  end

  // ---------------- command queue ----------------
  logic fifoOutValid;
  logic fifoOutReady;
  logic [FIFO_W-1:0] fifoOut;
  lhpdm_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) cmdQueue (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inValid(evValid),
    .inReady(fifoInReady),
    .inData(evData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  // ---------------- memory access engine ----------------
  lhpdm_slot_type slot;
  logic [7:0] displayMemory [0:MEM_DEPTH-1];
  logic [ADDR_W-1:0] addressCounter;
  logic [7:0] dataHoldingRegister;
  logic [7:0] instructionRegister;
  logic prefetchPend;
  logic incDir;
  logic readHoldBit;
  logic columnDirectionBit;
  logic rowDirectionBit;
  logic dispOn;
  logic sleepMode;
  logic standby;
  logic [3:0] lineGroups;
  logic exec;
  logic [1:0] execKind;
  logic [7:0] execData;
  logic powerOp;
  logic [ADDR_W-1:0] next_addressCounter;

  // host work only in its own slot; a pending fetch stalls the queue
  assign fifoOutReady = (slot == LHPDM_SLOT_HOST) && !prefetchPend;
  assign exec = fifoOutReady && fifoOutValid;
  assign execKind = fifoOut[9:8];
  assign execData = fifoOut[7:0];
  assign powerOp = ((execData & OP_MASK4) == OP_POWER) || ((execData & OP_MASK4) == OP_OSC_START);
  // one step per access in the chosen direction
  assign next_addressCounter = incDir ? addressCounter + 11'h001 : addressCounter - 11'h001;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slot <= LHPDM_SLOT_DISP;
    end else begin
      slot <= (slot == LHPDM_SLOT_DISP) ? LHPDM_SLOT_HOST : LHPDM_SLOT_DISP;
    end
  end

  always_ff @(posedge clk_sys) begin
    // data byte lands at the counter address, no host action needed
    if (exec && execKind == KIND_WRITE && !sleepMode && !standby) begin
      displayMemory[addressCounter] <= execData;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addressCounter <= '0;
      dataHoldingRegister <= '0;
      rdOut <= '0;
      prefetchPend <= 1'b0;
    end else if (prefetchPend && slot == LHPDM_SLOT_HOST) begin
      // fetch into the data holding register
      dataHoldingRegister <= displayMemory[addressCounter];
      prefetchPend <= 1'b0;
    end else if (exec && !sleepMode && !standby) begin
      if (execKind == KIND_WRITE) begin
        addressCounter <= next_addressCounter;
      end else if (execKind == KIND_READ) begin
        // pins show what was latched before this read
        rdOut <= dataHoldingRegister;
        prefetchPend <= 1'b1;
        if (!readHoldBit) begin
          addressCounter <= next_addressCounter;
        end
      end else if ((execData & OP_ADDR_LO_MASK) == OP_ADDR_LO_MASK) begin
        // page in upper bits, offset in lower seven
        addressCounter <= {addressCounter[10:7], execData[6:0]};
        prefetchPend <= 1'b1;
      end else if ((execData & OP_MASK4) == OP_ADDR_HI) begin
        addressCounter <= {execData[3:0], addressCounter[6:0]};
        prefetchPend <= 1'b1;
      end
    end
  end

  // instruction decode takes effect in the slot it is taken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      instructionRegister <= '0;
      incDir <= RST_DIR;
      readHoldBit <= 1'b0;
      columnDirectionBit <= 1'b0;
      rowDirectionBit <= 1'b0;
      dispOn <= 1'b0;
      sleepMode <= 1'b0;
      standby <= 1'b0;
      lineGroups <= RST_LINE_GROUPS;
    end else if (exec && execKind == KIND_INSTR && (powerOp || (!sleepMode && !standby))) begin
      instructionRegister <= execData;
      case (execData & OP_MASK4)
        OP_ENTRY: begin
          incDir <= execData[ENTRY_DIR_BIT];
          readHoldBit <= execData[ENTRY_HOLD_BIT];
        end
        OP_DRIVER: begin
          rowDirectionBit <= execData[DRV_ROWDIR_BIT];
          columnDirectionBit <= execData[DRV_COLDIR_BIT];
        end
        OP_POWER: begin
          dispOn <= execData[PWR_DISP_BIT];
          sleepMode <= execData[PWR_SLEEP_BIT];
          standby <= execData[PWR_STBY_BIT];
        end
        OP_OSC_START: begin
          standby <= 1'b0;
        end
        OP_LINES: begin
          lineGroups <= execData[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------- display refresh ----------------
  logic [7:0] oscDiv;
  logic tickPend;
  logic [6:0] colCnt;
  logic [6:0] rowCnt;
  logic [COL_NUM-1:0] lineShift;
  logic [6:0] rowLast;
  logic [6:0] colOffset;
  logic [7:0] dispByte;
  logic halted;
  assign halted = !dispOn || sleepMode || standby;
  // scan only programmed eight-row groups, capped at row 68; zero groups runs the count to 127
  assign rowLast = ({lineGroups, 3'h0} > 7'(ROW_NUM)) ? ROW_MAX_IDX
                                                    : 7'({lineGroups, 3'h0} - 7'h01);
  // offsets above 0x68 are never fetched for display
  assign colOffset = columnDirectionBit ? COL_LAST_OFF - colCnt : colCnt;
  assign dispByte = displayMemory[{rowCnt[6:3], colOffset}];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oscDiv <= '0;
      tickPend <= 1'b0;
      oscRun <= 1'b0;
    end else begin
      oscRun <= !standby;
      oscDiv <= (oscDiv == OSC_DIV_LAST || !oscRun) ? '0 : oscDiv + 8'h01;
      if (!oscRun) begin
        tickPend <= 1'b0;
      end else if (extSel ? (syncB[0] && !oscD) : (oscDiv == OSC_DIV_LAST)) begin
        tickPend <= 1'b1;
      end else if (slot == LHPDM_SLOT_DISP) begin
        tickPend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      colCnt <= '0;
      rowCnt <= '0;
      lineShift <= '0;
      columnDriverOutput <= '0;
      rowDriverOutput <= '0;
    end else if (halted) begin
      columnDriverOutput <= '0;
      rowDriverOutput <= '0;
      colCnt <= '0;
    end else if (tickPend && slot == LHPDM_SLOT_DISP) begin
      // one column bit per oscillator tick, taken in a display slot; row picks the bit
      lineShift <= {lineShift[COL_NUM-2:0], dispByte[rowCnt[2:0]]};
      if (colCnt == COL_MAX_IDX) begin
        colCnt <= '0;
        columnDriverOutput <= {lineShift[COL_NUM-2:0], dispByte[rowCnt[2:0]]};
        rowDriverOutput <= '0;
        // row scan order follows the row direction bit
        rowDriverOutput[rowDirectionBit ? ROW_MAX_IDX - rowCnt : rowCnt] <= 1'b1;
        rowCnt <= (rowCnt >= rowLast) ? '0 : rowCnt + 7'h01;
      end else begin
        colCnt <= colCnt + 7'h01;
      end
    end
  end

  // ---------------- checks ----------------
  sequence seqHostRead;
    exec && execKind == KIND_READ && !sleepMode && !standby;
  endsequence
  sequence seqFetchDone;
    !prefetchPend [*2];
  endsequence

  chk_write_steps: assert property (@(posedge clk_sys) disable iff (!resetn)
    (exec && execKind == KIND_WRITE && !sleepMode && !standby) |=>
      (addressCounter == ($past(incDir) ? $past(addressCounter) + 11'h001
                                        : $past(addressCounter) - 11'h001)))
    else $error("counter did not step after write");
  chk_write_stored: assert property (@(posedge clk_sys) disable iff (!resetn)
    (exec && execKind == KIND_WRITE && !sleepMode && !standby) |=>
      (displayMemory[$past(addressCounter)] == $past(execData)))
    else $error("written byte not in memory");
  chk_read_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (seqHostRead and readHoldBit) |=> $stable(addressCounter))
    else $error("counter moved under read hold");
  chk_read_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
    seqHostRead |=> (rdOut == $past(dataHoldingRegister)) && prefetchPend)
    else $error("read did not return latched byte");
  chk_fetch_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(prefetchPend) |-> ##[1:2] seqFetchDone)
    else $error("prefetch not completed in time");
  chk_fetch_value: assert property (@(posedge clk_sys) disable iff (!resetn)
    (prefetchPend && slot == LHPDM_SLOT_HOST) |=>
      (dataHoldingRegister == displayMemory[$past(addressCounter)]))
    else $error("data holding register not loaded");
  chk_slot_split: assert property (@(posedge clk_sys) disable iff (!resetn)
    exec |-> slot == LHPDM_SLOT_HOST)
    else $error("host operation in display slot");
  chk_blank_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
    halted |=> (columnDriverOutput == '0) && (rowDriverOutput == '0))
    else $error("drivers not grounded when halted");
  chk_osc_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
    standby [*3] |-> !oscRun && !tickPend)
    else $error("oscillator running in standby");
endmodule : lhpdm_top
`default_nettype wire

// *** lhpdm_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module lhpdm_host_model (
  input wire logic clk_sys,
  output logic chipSelectN,
  output logic registerSelect,
  output logic strobeClkIn,
  output logic rwSdaIn,
  input wire logic rwSdaOut,
  input wire logic rwSdaOe,
  output logic [7:0] hostDataBusIn,
  input wire logic [7:0] hostDataBusOut,
  input wire logic hostDataBusOe
);
  logic [7:0] drv;
  logic busOwn;
  logic sda;
  logic sdaOwn;

  // released lines show the inverse, so a missing drive never reads back as a match
  assign hostDataBusIn = hostDataBusOe ? hostDataBusOut : (busOwn ? drv : ~drv);
  assign rwSdaIn = rwSdaOe ? rwSdaOut : (sdaOwn ? sda : ~sda);

  initial begin
    chipSelectN = 1'b1;
    registerSelect = 1'b0;
    strobeClkIn = 1'b0;
    drv = 8'h00;
    busOwn = 1'b1;
    sda = 1'b0;
    sdaOwn = 1'b1;
  end

  // strobe phases of six cycles keep well clear of the pin synchronisers
  task automatic busWr(input logic rs, input logic [7:0] d);
    @(negedge clk_sys);
    chipSelectN = 1'b0;
    registerSelect = rs;
    sda = 1'b0;
    drv = d;
    busOwn = 1'b1;
    strobeClkIn = 1'b1;
    repeat (6) @(negedge clk_sys);
    strobeClkIn = 1'b0;
    repeat (6) @(negedge clk_sys);
    chipSelectN = 1'b1;
  endtask : busWr

  task automatic busRd(output logic [7:0] q);
    @(negedge clk_sys);
    chipSelectN = 1'b0;
    registerSelect = 1'b1;
    sda = 1'b1;
    busOwn = 1'b0;
    strobeClkIn = 1'b1;
    repeat (6) @(negedge clk_sys);
    q = hostDataBusOe ? hostDataBusOut : 8'hxx;
    strobeClkIn = 1'b0;
    repeat (6) @(negedge clk_sys);
    chipSelectN = 1'b1;
    sda = 1'b0;
    busOwn = 1'b1;
  endtask : busRd

  // serial clock idles low between frames and runs only inside them
  task automatic serXfer(input logic rw, input logic rs, input logic [7:0] d,
                         output logic [7:0] q);
    logic [9:0] f;
    f = {rw, rs, d};
    q = 8'h00;
    @(negedge clk_sys);
    chipSelectN = 1'b0;
    // the odd offset keeps every link edge clear of the sampling clock edge
    #101;
    for (int i = 9; i >= 0; i--) begin
      sda = f[i];
      sdaOwn = !(rw && i < 8);
      #62.5;
      strobeClkIn = 1'b1;
      if (i < 8) q[i] = rwSdaOe ? rwSdaOut : 1'bx;
      #62.5;
      strobeClkIn = 1'b0;
    end
    #100;
    chipSelectN = 1'b1;
    sdaOwn = 1'b1;
    #300;
  endtask : serXfer
endmodule : lhpdm_host_model

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import lhpdm_pkg::*;
  typedef struct packed {
    logic [3:0] pg;
    logic [6:0] off;
    logic [7:0] dat;
  } lhpdm_row_type;

  logic clk_sys, resetn, csN, rs, scl, sdaIn, sdaOut, sdaOe, dbOe, oscRun, hostBusy;
  logic [2:0] ims;
  logic [7:0] dbIn, dbOut, q;
  logic [COL_NUM-1:0] col;
  logic [ROW_NUM-1:0] row;
  int failCount, nTests, cyc;
  lhpdm_row_type rows [5];

  lhpdm_top dut (.clk_sys(clk_sys), .resetn(resetn), .interfaceSelectPins(ims),
    .chipSelectN(csN), .registerSelect(rs), .strobeClkIn(scl), .rwSdaIn(sdaIn),
    .rwSdaOut(sdaOut), .rwSdaOe(sdaOe), .hostDataBusIn(dbIn), .hostDataBusOut(dbOut),
    .hostDataBusOe(dbOe), .oscillatorInputPin(1'b0), .extClockSel(1'b0),
    .oscRun(oscRun), .hostBusy(hostBusy), .columnDriverOutput(col),
    .rowDriverOutput(row));

  lhpdm_host_model host (.clk_sys(clk_sys), .chipSelectN(csN), .registerSelect(rs),
    .strobeClkIn(scl), .rwSdaIn(sdaIn), .rwSdaOut(sdaOut), .rwSdaOe(sdaOe),
    .hostDataBusIn(dbIn), .hostDataBusOut(dbOut), .hostDataBusOe(dbOe));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      failCount++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    nTests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      failCount++;
    end
  endtask : chk

  task automatic setAddr(input logic [3:0] pg, input logic [6:0] off);
    host.busWr(1'b0, {4'h1, pg});
    host.busWr(1'b0, {1'b1, off});
  endtask : setAddr

  task automatic readChk(input string nm, input logic [7:0] e);
    host.busRd(q);
    chk(nm, e, q);
  endtask : readChk

  initial begin
    ims = 3'b010;
    resetn = 1'b0;
    failCount = 0;
    nTests = 0;
    cyc = 0;
    rows[0] = '{4'h0, 7'h00, 8'h5a};
    rows[1] = '{4'h1, 7'h68, 8'ha5};
    rows[2] = '{4'h2, 7'h69, 8'h7e};
    rows[3] = '{4'h9, 7'h3c, 8'h81};
    rows[4] = '{4'h9, 7'h7f, 8'hc3};
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("col reset", 8'h00, {7'h00, |col});
    chk("row reset", 8'h00, {7'h00, |row});
    chk("bus oe", 8'h00, {7'h00, dbOe});
    // refresh runs during the host traffic below up to the sleep instruction 0x4c
    host.busWr(1'b0, 8'h48);
    for (int i = 0; i < 5; i++) begin
      setAddr(rows[i].pg, rows[i].off);
      host.busWr(1'b1, rows[i].dat);
    end
    for (int i = 0; i < 5; i++) begin
      setAddr(rows[i].pg, rows[i].off);
      host.busRd(q);
      readChk("row data", rows[i].dat);
    end
    setAddr(4'h3, 7'h10);
    for (int i = 1; i < 4; i++) host.busWr(1'b1, 8'(i * 17));
    setAddr(4'h3, 7'h10);
    host.busRd(q);
    for (int i = 1; i < 4; i++) readChk("step up", 8'(i * 17));
    host.busWr(1'b0, 8'h20);
    setAddr(4'h3, 7'h20);
    host.busWr(1'b1, 8'h44);
    host.busWr(1'b1, 8'h55);
    setAddr(4'h3, 7'h20);
    host.busRd(q);
    readChk("down a", 8'h44);
    readChk("down b", 8'h55);
    host.busWr(1'b0, 8'h23);
    setAddr(4'h3, 7'h10);
    host.busRd(q);
    readChk("hold a", 8'h11);
    readChk("hold b", 8'h11);
    host.busWr(1'b1, 8'h66);
    host.busWr(1'b0, 8'h22);
    setAddr(4'h3, 7'h10);
    host.busRd(q);
    readChk("modify write", 8'h66);
    for (int k = 0; k < 400 && row == '0; k++) @(negedge clk_sys);
    chk("row scan", 8'h01, {7'h00, $onehot(row)});
    setAddr(4'h0, 7'h00);
    host.busWr(1'b1, 8'hff);
    setAddr(4'h0, 7'h68);
    host.busWr(1'b1, 8'h00);
    host.busWr(1'b0, 8'h61);
    // two full lines must pass before the latched line is clean
    repeat (1800) @(negedge clk_sys);
    chk("col normal", 8'h02, {6'h00, col[COL_NUM-1], col[0]});
    chk("row normal", 8'h01, {7'h00, |row[7:0]});
    host.busWr(1'b0, 8'h33);
    repeat (1800) @(negedge clk_sys);
    chk("col reversed", 8'h01, {6'h00, col[COL_NUM-1], col[0]});
    chk("row reversed", 8'h01, {7'h00, |row[ROW_NUM-1:ROW_NUM-8]});
    host.busWr(1'b0, 8'h4c);
    repeat (40) @(negedge clk_sys);
    chk("row sleep", 8'h00, {7'h00, |row});
    chk("col sleep", 8'h00, {7'h00, |col});
    host.busWr(1'b0, 8'h42);
    repeat (20) @(negedge clk_sys);
    chk("osc standby", 8'h00, {7'h00, oscRun});
    host.busWr(1'b0, 8'h50);
    repeat (20) @(negedge clk_sys);
    chk("osc start", 8'h01, {7'h00, oscRun});
    // back-to-back writes through the command queue must never back it up
    setAddr(4'h5, 7'h00);
    for (int i = 0; i < FIFO_D; i++) begin
      host.busWr(1'b1, 8'(8'ha0 + i));
      chk("queue busy", 8'h00, {7'h00, hostBusy});
    end
    setAddr(4'h5, 7'h00);
    host.busRd(q);
    for (int i = 0; i < FIFO_D; i++) readChk("queue order", 8'(8'ha0 + i));
    chk("queue idle", 8'h00, {7'h00, hostBusy});
    chk("bus released", 8'h00, {7'h00, dbOe});
    chk("sda idle", 8'h00, {7'h00, sdaOe});
    resetn = 1'b0;
    ims = 3'b000;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (8) @(negedge clk_sys);
    host.serXfer(1'b0, 1'b0, 8'h82, q);
    host.serXfer(1'b0, 1'b1, 8'hb7, q);
    host.serXfer(1'b0, 1'b0, 8'h82, q);
    host.serXfer(1'b1, 1'b1, 8'h00, q);
    host.serXfer(1'b1, 1'b1, 8'h00, q);
    chk("serial read", 8'hb7, q);
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
